// ### inc/ldd_pkg.sv
// What this block does
// - The register/memory disjunction ORs source and destination at byte, word or long size and stores the result.
// - Address register contents are never an operand of the register/memory disjunction.
// - After a disjunction, extend is kept, negative follows the result top bit, zero marks a zero result, V and C clear.
// - Bits 11 to 9 of the register/memory disjunction select one of eight data registers.
// - Direction/size codes 000, 001, 010 store into the data register; 100, 101, 110 store to the effective address.
// - An effective address source may use any data mode, immediate included, but not address register direct.
// - An effective address destination may use only memory alterable modes.
// - The immediate disjunction ORs the immediate data into the destination operand and stores the result there.
// - The immediate operand has the width of the operation size and is used at that width.
// - The immediate disjunction size field in bits 7 to 6, under a zero upper byte, reads 00 byte, 01 word, 10 long.
// - Immediate disjunction and complement destinations accept only data alterable modes.
// - The immediate comes after the opcode: low byte of one word, one word, or the next two words.
// - The complement inverts the destination at its size, stores it, keeps extend, sets N and Z, clears V and C.
package ldd_pkg;
	localparam int DATA_W = 32;
	localparam int DREG_COUNT = 8;
	localparam logic [3:0] OR_TOP = 4'hC;
	localparam logic [7:0] NOT_TOP = 8'h46;
	localparam logic [7:0] IMM_TOP = 8'h00;
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_LONG = 2'h2;
	localparam logic [1:0] SZ_BAD = 2'h3;
	localparam logic [2:0] M_DREG = 3'h0;
	localparam logic [2:0] M_AREG = 3'h1;
	localparam logic [2:0] M_EXT = 3'h7;
	localparam logic [2:0] R_ABS_W = 3'h0;
	localparam logic [2:0] R_ABS_L = 3'h1;
	localparam logic [2:0] R_PC_D16 = 3'h2;
	localparam logic [2:0] R_PC_IDX = 3'h3;
	localparam logic [2:0] R_IMM = 3'h4;
	localparam int CC_X = 4;
	localparam int CC_N = 3;
	localparam int CC_Z = 2;
	localparam int CC_V = 1;
	localparam int CC_C = 0;
	localparam logic [4:0] CCR_RESET = 5'h00;
	localparam logic [31:0] DREG_RESET = 32'h00000000;
	localparam logic [31:0] MASK_BYTE = 32'h000000FF;
	localparam logic [31:0] MASK_WORD = 32'h0000FFFF;
	localparam logic [31:0] MASK_LONG = 32'hFFFFFFFF;
	localparam int F_TOP_HI = 15;
	localparam int F_TOP_LO = 8;
	localparam int F_OR_HI = 15;
	localparam int F_OR_LO = 12;
	localparam int F_REG_HI = 11;
	localparam int F_REG_LO = 9;
	localparam int F_DIR = 8;
	localparam int F_SZ_HI = 7;
	localparam int F_SZ_LO = 6;
	localparam int F_MODE_HI = 5;
	localparam int F_MODE_LO = 3;
	localparam int F_EAREG_HI = 2;
	localparam int F_EAREG_LO = 0;
	localparam int HALF_W = 16;

	typedef struct packed {
		logic write;
		logic [2:0] mode;
		logic [2:0] reg_num;
		logic [1:0] size;
		logic [31:0] wdata;
	} ldd_ea_req_type;

	function automatic logic ea_is_data(input logic [2:0] mode, input logic [2:0] rnum);
		if (mode == M_AREG) begin
			return 1'b0;
		end
		if (mode == M_EXT) begin
			return rnum <= R_IMM;
		end
		return 1'b1;
	endfunction

	function automatic logic ea_is_data_alt(input logic [2:0] mode, input logic [2:0] rnum);
		if (mode == M_AREG) begin
			return 1'b0;
		end
		if (mode == M_EXT) begin
			return (rnum == R_ABS_W) || (rnum == R_ABS_L);
		end
		return 1'b1;
	endfunction

	function automatic logic ea_is_mem_alt(input logic [2:0] mode, input logic [2:0] rnum);
		return ea_is_data_alt(mode, rnum) && (mode != M_DREG);
	endfunction

	function automatic logic [31:0] size_mask(input logic [1:0] size);
		case (size)
			SZ_BYTE: return MASK_BYTE;
			SZ_WORD: return MASK_WORD;
			default: return MASK_LONG;
		endcase
	endfunction
endpackage

// ### rtl/ldd_logic_unit.sv
`timescale 1ns/1ps
module ldd_logic_unit #(
	parameter int W = 32
) (
	input wire logic op_not_in,
	input wire logic [1:0] size_in,
	input wire logic [W-1:0] src_in,
	input wire logic [W-1:0] dst_in,
	output logic [W-1:0] result_out,
	output logic neg_out,
	output logic zero_out
);
	import ldd_pkg::*;

	logic [W-1:0] raw;
	logic [31:0] mask_full;
	logic [W-1:0] mask;
	logic [W-1:0] top_bit;

	// The sign bit is taken from the size mask itself, so no bit position is wired in per size.
	always_comb begin
		mask_full = size_mask(size_in);
		mask = mask_full[W-1:0];
		top_bit = mask ^ (mask >> 1);
		raw = op_not_in ? ~dst_in : (src_in | dst_in);
		result_out = raw & mask;
		neg_out = |(raw & top_bit);
		zero_out = (result_out == '0);
	end
endmodule

// ### rtl/ldd_top.sv
`timescale 1ns/1ps
module ldd_top (
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic word_valid_in,
	input wire logic [15:0] word_in,
	output logic word_ready_out,
	output ldd_pkg::ldd_ea_req_type ea_req_out,
	output logic ea_req_valid_out,
	input wire logic ea_done_in,
	input wire logic [31:0] ea_rdata_in,
	input wire logic [2:0] dreg_sel_in,
	output logic [31:0] dreg_value_out,
	output logic [4:0] ccr_out,
	output logic done_out,
	output logic illegal_out
);
	import ldd_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {S_OPCODE, S_IMM_HI, S_IMM_LO, S_EA_RD, S_EXEC, S_EA_WR} ldd_state_type;

	logic rst_meta_q;
	logic rst_n_q;

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	ldd_state_type state_q, state_d;
	logic op_not_q, op_not_d;
	logic to_dreg_q, to_dreg_d;
	logic src_ea_q, src_ea_d;
	logic rd_src_q, rd_src_d;
	logic [1:0] size_q, size_d;
	logic [2:0] mode_q, mode_d;
	logic [2:0] ea_reg_q, ea_reg_d;
	logic [2:0] dn_q, dn_d;
	logic [31:0] a_q, a_d;
	logic [31:0] b_q, b_d;
	logic [31:0] dreg_q [DREG_COUNT];
	logic [31:0] dreg_d [DREG_COUNT];
	logic [4:0] ccr_q, ccr_d;
	logic word_ready_q, word_ready_d;
	ldd_ea_req_type ea_req_q, ea_req_d;
	logic ea_req_valid_q, ea_req_valid_d;
	logic [31:0] dreg_value_q, dreg_value_d;
	logic done_q, done_d;
	logic illegal_q, illegal_d;

	logic [31:0] res;
	logic res_neg;
	logic res_zero;
	logic word_take;
	logic [2:0] w_mode;
	logic [2:0] w_reg;
	logic [1:0] w_size;
	logic is_or;
	logic is_imm;
	logic is_not;
	logic legal;

	ldd_logic_unit #(
		.W(DATA_W)
	) u_logic (
		.op_not_in(op_not_q),
		.size_in(size_q),
		.src_in(a_q),
		.dst_in(b_q),
		.result_out(res),
		.neg_out(res_neg),
		.zero_out(res_zero)
	);

	// A narrower write keeps the untouched upper bits of the data register.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [1:0] size);
		return (old & ~size_mask(size)) | (val & size_mask(size));
	endfunction

	// Flags commit together with the result, so a stalled memory write never shows them early.
	function automatic logic [4:0] flags_after(input logic [4:0] old, input logic neg, input logic zero);
		logic [4:0] f;
		f = old;
		f[CC_N] = neg;
		f[CC_Z] = zero;
		f[CC_V] = 1'b0;
		f[CC_C] = 1'b0;
		return f;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		word_take = word_valid_in && word_ready_q;
		w_mode = word_in[F_MODE_HI:F_MODE_LO];
		w_reg = word_in[F_EAREG_HI:F_EAREG_LO];
		w_size = word_in[F_SZ_HI:F_SZ_LO];
		is_or = word_in[F_OR_HI:F_OR_LO] == OR_TOP;
		is_imm = word_in[F_TOP_HI:F_TOP_LO] == IMM_TOP;
		is_not = word_in[F_TOP_HI:F_TOP_LO] == NOT_TOP;
		legal = 1'b0;
		if (is_or) begin
			legal = (w_size != SZ_BAD) && (word_in[F_DIR] ? ea_is_mem_alt(w_mode, w_reg)
				: ea_is_data(w_mode, w_reg));
		end else if (is_imm || is_not) begin
			legal = (w_size != SZ_BAD) && ea_is_data_alt(w_mode, w_reg);
		end
	end

	always_comb begin
		state_d = state_q;
		op_not_d = op_not_q;
		to_dreg_d = to_dreg_q;
		src_ea_d = src_ea_q;
		rd_src_d = rd_src_q;
		size_d = size_q;
		mode_d = mode_q;
		ea_reg_d = ea_reg_q;
		dn_d = dn_q;
		a_d = a_q;
		b_d = b_q;
		dreg_d = dreg_q;
		ccr_d = ccr_q;
		ea_req_d = ea_req_q;
		ea_req_valid_d = 1'b0;
		done_d = 1'b0;
		illegal_d = 1'b0;
		unique case (state_q)
			S_OPCODE: begin
				if (word_take && (is_or || is_imm || is_not)) begin
					if (!legal) begin
						illegal_d = 1'b1;
					end else begin
						op_not_d = is_not;
						size_d = w_size;
						mode_d = w_mode;
						ea_reg_d = w_reg;
						dn_d = word_in[F_REG_HI:F_REG_LO];
						src_ea_d = is_or && !word_in[F_DIR];
						to_dreg_d = src_ea_d || (w_mode == M_DREG);
						a_d = '0;
						b_d = dreg_q[w_reg];
						if (is_or && word_in[F_DIR]) begin
							a_d = dreg_q[word_in[F_REG_HI:F_REG_LO]];
						end
						if (src_ea_d) begin
							a_d = dreg_q[w_reg];
							b_d = dreg_q[word_in[F_REG_HI:F_REG_LO]];
						end
						if (is_imm || (src_ea_d && w_mode == M_EXT && w_reg == R_IMM)) begin
							state_d = (w_size == SZ_LONG) ? S_IMM_HI : S_IMM_LO;
						end else if (src_ea_d && w_mode == M_DREG) begin
							state_d = S_EXEC;
						end else if (!src_ea_d && w_mode == M_DREG) begin
							state_d = S_EXEC;
						end else begin
							rd_src_d = src_ea_d;
							state_d = S_EA_RD;
						end
					end
				end
			end
			S_IMM_HI: begin
				if (word_take) begin
					a_d = {word_in, a_q[HALF_W-1:0]};
					state_d = S_IMM_LO;
				end
			end
			S_IMM_LO: begin
				if (word_take) begin
					a_d = ({a_q[DATA_W-1:HALF_W], word_in}) & size_mask(size_q);
					if (src_ea_d || mode_q == M_DREG) begin
						state_d = S_EXEC;
					end else begin
						rd_src_d = 1'b0;
						state_d = S_EA_RD;
					end
				end
			end
			S_EA_RD: begin
				ea_req_valid_d = !ea_done_in;
				ea_req_d.write = 1'b0;
				ea_req_d.mode = mode_q;
				ea_req_d.reg_num = ea_reg_q;
				ea_req_d.size = size_q;
				ea_req_d.wdata = '0;
				if (ea_req_valid_q && ea_done_in) begin
					if (rd_src_q) begin
						a_d = ea_rdata_in & size_mask(size_q);
					end else begin
						b_d = ea_rdata_in & size_mask(size_q);
					end
					state_d = S_EXEC;
				end
			end
			S_EXEC: begin
				if (to_dreg_q) begin
					ccr_d = flags_after(ccr_q, res_neg, res_zero);
					if (src_ea_q) begin
						dreg_d[dn_q] = merge(dreg_q[dn_q], res, size_q);
					end else begin
						dreg_d[ea_reg_q] = merge(dreg_q[ea_reg_q], res, size_q);
					end
					done_d = 1'b1;
					state_d = S_OPCODE;
				end else begin
					ea_req_d.write = 1'b1;
					ea_req_d.mode = mode_q;
					ea_req_d.reg_num = ea_reg_q;
					ea_req_d.size = size_q;
					ea_req_d.wdata = res;
					ea_req_valid_d = 1'b1;
					state_d = S_EA_WR;
				end
			end
			S_EA_WR: begin
				ea_req_valid_d = !ea_done_in;
				if (ea_done_in) begin
					ccr_d = flags_after(ccr_q, res_neg, res_zero);
					done_d = 1'b1;
					state_d = S_OPCODE;
				end
			end
		endcase
		// The fetch handshake is registered, so ready is decided from the state about to be entered.
		word_ready_d = (state_d == S_OPCODE) || (state_d == S_IMM_HI) || (state_d == S_IMM_LO);
		if ((state_d == S_OPCODE) && (done_d || illegal_d)) begin
			word_ready_d = 1'b0;
		end
		dreg_value_d = dreg_d[dreg_sel_in];
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= S_OPCODE;
			op_not_q <= 1'b0;
			to_dreg_q <= 1'b0;
			src_ea_q <= 1'b0;
			rd_src_q <= 1'b0;
			size_q <= SZ_BYTE;
			mode_q <= M_DREG;
			ea_reg_q <= '0;
			dn_q <= '0;
			a_q <= '0;
			b_q <= '0;
			for (int i = 0; i < DREG_COUNT; i++) begin
				dreg_q[i] <= DREG_RESET;
			end
			ccr_q <= CCR_RESET;
			word_ready_q <= 1'b0;
			ea_req_q <= '0;
			ea_req_valid_q <= 1'b0;
			dreg_value_q <= DREG_RESET;
			done_q <= 1'b0;
			illegal_q <= 1'b0;
		end else begin
			state_q <= state_d;
			op_not_q <= op_not_d;
			to_dreg_q <= to_dreg_d;
			src_ea_q <= src_ea_d;
			rd_src_q <= rd_src_d;
			size_q <= size_d;
			mode_q <= mode_d;
			ea_reg_q <= ea_reg_d;
			dn_q <= dn_d;
			a_q <= a_d;
			b_q <= b_d;
			dreg_q <= dreg_d;
			ccr_q <= ccr_d;
			word_ready_q <= word_ready_d;
			ea_req_q <= ea_req_d;
			ea_req_valid_q <= ea_req_valid_d;
			dreg_value_q <= dreg_value_d;
			done_q <= done_d;
			illegal_q <= illegal_d;
		end
	end

	assign word_ready_out = word_ready_q;
	assign ea_req_out = ea_req_q;
	assign ea_req_valid_out = ea_req_valid_q;
	assign dreg_value_out = dreg_value_q;
	assign ccr_out = ccr_q;
	assign done_out = done_q;
	assign illegal_out = illegal_q;
endmodule

// ### bench/ldd_checker.sv
`timescale 1ns/1ps
module ldd_checker (
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire ldd_pkg::ldd_ea_req_type ea_req_out,
	input wire logic ea_req_valid_out,
	input wire logic ea_done_in,
	input wire logic [4:0] ccr_out,
	input wire logic done_out,
	input wire logic illegal_out
);
	import ldd_pkg::*;
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!resetn_in);
	property p_done_pulse;
		done_out |=> !done_out;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
	property p_ill_pulse;
		illegal_out |-> !done_out && !ea_req_valid_out ##1 !illegal_out;
	endproperty
	a_ill_pulse: assert property (p_ill_pulse) else $error("illegal opcode acted upon");
	property p_vc;
		ccr_out[1:0] == 2'h0 && ccr_out[4] == 1'b0;
	endproperty
	a_vc: assert property (p_vc) else $error("extend, overflow or carry set");
	property p_ccr_change;
		$changed(ccr_out) |-> done_out;
	endproperty
	a_ccr_change: assert property (p_ccr_change) else $error("flags moved without completion");
	property p_no_areg;
		ea_req_valid_out |-> ea_req_out.mode != 3'h1;
	endproperty
	a_no_areg: assert property (p_no_areg) else $error("address register used as operand");
	property p_wr_mode;
		ea_req_valid_out && ea_req_out.write |-> ea_req_out.mode != 3'h0
			&& !(ea_req_out.mode == 3'h7 && ea_req_out.reg_num > 3'h1);
	endproperty
	a_wr_mode: assert property (p_wr_mode) else $error("write to a mode that is not alterable");
	property p_rd_mode;
		ea_req_valid_out && !ea_req_out.write |-> !(ea_req_out.mode == 3'h7 && ea_req_out.reg_num > 3'h4);
	endproperty
	a_rd_mode: assert property (p_rd_mode) else $error("read from a non-data mode");
	property p_stable;
		ea_req_valid_out && $past(ea_req_valid_out) |-> $stable(ea_req_out);
	endproperty
	a_stable: assert property (p_stable) else $error("request changed while outstanding");
	property p_drop;
		ea_done_in && ea_req_valid_out |=> !ea_req_valid_out;
	endproperty
	a_drop: assert property (p_drop) else $error("request held after done");
	property p_wr_done;
		ea_req_valid_out && ea_req_out.write && ea_done_in |-> ##[1:3] done_out;
	endproperty
	a_wr_done: assert property (p_wr_done) else $error("write not followed by completion");
endmodule
bind ldd_top ldd_checker chk_u (.clock_in(clock_in), .resetn_in(resetn_in), .ea_req_out(ea_req_out),
	.ea_req_valid_out(ea_req_valid_out), .ea_done_in(ea_done_in), .ccr_out(ccr_out),
	.done_out(done_out), .illegal_out(illegal_out));

// ### bench/ldd_mem_model.sv
`timescale 1ns/1ps
module ldd_mem_model (
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire ldd_pkg::ldd_ea_req_type req_in,
	input wire logic valid_in,
	input wire logic [31:0] rd_value_in,
	input wire logic [3:0] delay_in,
	output logic done_out,
	output logic [31:0] rdata_out,
	output logic [31:0] wr_data_out
);
	import ldd_pkg::*;
	logic [3:0] cnt;
	logic hold;
	// Outside the done cycle the read data is inverted, so a late sample cannot match by luck.
	always @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt <= 4'h0;
			hold <= 1'b0;
			done_out <= 1'b0;
			rdata_out <= 32'h00000000;
			wr_data_out <= 32'h00000000;
		end else begin
			done_out <= 1'b0;
			rdata_out <= ~rd_value_in;
			if (hold) begin
				hold <= valid_in;
			end else if (valid_in && cnt == delay_in) begin
				done_out <= 1'b1;
				hold <= 1'b1;
				cnt <= 4'h0;
				rdata_out <= rd_value_in;
				if (req_in.write) begin
					wr_data_out <= req_in.wdata;
				end
			end else if (valid_in) begin
				cnt <= cnt + 4'h1;
			end
		end
	end
endmodule

// ### bench/ldd_tb.sv
`timescale 1ns/1ps
module testbench;
	import ldd_pkg::*;
	logic clock_in = 0;
	logic resetn_in = 0;
	logic word_valid_in = 0;
	logic [15:0] word_in = 16'h0000;
	logic [2:0] dreg_sel_in = 3'h0;
	logic [31:0] rd_value = 32'h00000000;
	logic [3:0] dly = 4'h0;
	logic word_ready_out, ea_req_valid_out, ea_done_in, done_out, illegal_out;
	ldd_ea_req_type ea_req_out;
	logic [31:0] ea_rdata_in, dreg_value_out, wr_data;
	logic [4:0] ccr_out;
	logic [15:0] bad_ops [8] = '{16'hC100, 16'hC048, 16'hC07D, 16'hC13A, 16'h00C0, 16'h0008, 16'h003C, 16'h4648};
	int bad_count = 0;
	int check_count = 0;
	always #20 clock_in = ~clock_in;
	ldd_top dut_u (.clock_in(clock_in), .resetn_in(resetn_in), .word_valid_in(word_valid_in),
		.word_in(word_in), .word_ready_out(word_ready_out), .ea_req_out(ea_req_out),
		.ea_req_valid_out(ea_req_valid_out), .ea_done_in(ea_done_in), .ea_rdata_in(ea_rdata_in),
		.dreg_sel_in(dreg_sel_in), .dreg_value_out(dreg_value_out), .ccr_out(ccr_out),
		.done_out(done_out), .illegal_out(illegal_out));
	ldd_mem_model mem_u (.clock_in(clock_in), .resetn_in(resetn_in), .req_in(ea_req_out),
		.valid_in(ea_req_valid_out), .rd_value_in(rd_value), .delay_in(dly), .done_out(ea_done_in),
		.rdata_out(ea_rdata_in), .wr_data_out(wr_data));
	////////////////////////////////////////////////////////////////
	task results;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task tick;
		@(posedge clock_in);
		#1;
	endtask
	// Valid stays up between words so no signal is driven twice in one time step.
	task put(input logic [15:0] w);
		int i;
		word_valid_in = 1'b1;
		word_in = w;
		// Ready is looked at just after an edge, so it is the value the design will use at the next edge.
		for (i = 0; i < 50; i++) begin
			if (word_ready_out === 1'b1) break;
			tick;
		end
		if (i == 50) begin
			bad_count++;
			results();
		end
		tick;
	endtask
	task ins(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c, input int n, input logic ill);
		int i;
		put(a);
		if (n > 1) put(b);
		if (n > 2) put(c);
		word_valid_in = 1'b0;
		for (i = 0; i < 50; i++) begin
			if (done_out === 1'b1 || illegal_out === 1'b1) break;
			tick;
		end
		chk({31'h0, illegal_out}, {31'h0, ill});
		if (i == 50) begin
			bad_count++;
			results();
		end
	endtask
	task cc(input logic [4:0] e);
		chk({27'h0, ccr_out}, {27'h0, e});
	endtask
	task dchk(input logic [2:0] s, input logic [31:0] e);
		dreg_sel_in = s;
		tick;
		tick;
		chk(dreg_value_out, e);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) tick;
		resetn_in = 1'b1;
		repeat (4) tick;
		cc(5'h00);
		ins(16'hC6BC, 16'h1234, 16'h5678, 3, 1'b0);
		cc(5'h00);
		dchk(3'h3, 32'h12345678);
		ins(16'h0003, 16'hAA80, 16'h0000, 2, 1'b0);
		cc(5'h08);
		dchk(3'h3, 32'h123456F8);
		ins(16'h0045, 16'h0000, 16'h0000, 2, 1'b0);
		cc(5'h04);
		$display("test 1 end");
		ins(16'h4685, 16'h0000, 16'h0000, 1, 1'b0);
		cc(5'h08);
		dchk(3'h5, 32'hFFFFFFFF);
		ins(16'h4645, 16'h0000, 16'h0000, 1, 1'b0);
		cc(5'h04);
		dchk(3'h5, 32'hFFFF0000);
		$display("test 2 end");
		rd_value = 32'h00000F01;
		dly = 4'h3;
		ins(16'hC710, 16'h0000, 16'h0000, 1, 1'b0);
		chk(wr_data & 32'h000000FF, 32'h000000F9);
		cc(5'h08);
		rd_value = 32'h00000001;
		dly = 4'h0;
		ins(16'h009A, 16'h8000, 16'h0000, 3, 1'b0);
		chk(wr_data, 32'h80000001);
		cc(5'h08);
		rd_value = 32'h00000100;
		dly = 4'h7;
		ins(16'h0011, 16'h0000, 16'h0000, 2, 1'b0);
		chk(wr_data & 32'h000000FF, 32'h00000000);
		cc(5'h04);
		$display("test 3 end");
		for (int k = 0; k < 8; k++) begin
			ins(bad_ops[k], 16'h0000, 16'h0000, 1, 1'b1);
		end
		cc(5'h04);
		dchk(3'h3, 32'h123456F8);
		$display("test 4 end");
		rd_value = 32'h00018421;
		dly = 4'h2;
		ins(16'hCA53, 16'h0000, 16'h0000, 1, 1'b0);
		cc(5'h08);
		dchk(3'h5, 32'hFFFF8421);
		ins(16'hC685, 16'h0000, 16'h0000, 1, 1'b0);
		cc(5'h08);
		dchk(3'h3, 32'hFFFFD6F9);
		$display("test 5 end");
		results();
	end
endmodule
